// File: verilog/psq_regs.svh
// Purpose: offsets, field positions, reset values and times of the port
//          detect/classify sequencer
// Assumes: 32-bit register words, byte addresses on an 8-bit address
// Notes:   cycle counts are derived inside the sequencer from these times
//
// Behaviour
// - force two currents, subtract the measured voltages
// - voltage phase only after good current phase
// - signature in valid window reports good detection
// - below one volt at first step: short
// - outcomes encoded as distinct detection codes
// - port above ten volts: outside-range code
// - manual: one detection per host command
// - semi-auto polls, never powers without command
// - back off 100 ms, midspan 2 s
// - high power semi-auto: power only if good
// - automatic mode powers good port by itself
// - detection inhibited: strap low, shutdown, disabled (strap low only blocks automatic mode; host can enable manual or semi-auto)
// - legacy capacitance detection off by default
// - classify after detection, manual only on command
// - classify 12 ms at 18 V, store class
// - classes 0 to 4, class 0 like 3
// - automatic mode sets limits from class
// - classification inhibited: strap low, shutdown, disabled (strap low only blocks automatic mode; host can enable manual or semi-auto)
// - class 4 with two events: mark, reclassify
// - second event sets high-power status flag
// - second event only after class 4
// - host may change limits while powered
`ifndef PSQ_REGS_SVH
`define PSQ_REGS_SVH

`define PSQ_OFF_CTRL    8'h00
`define PSQ_OFF_CMD     8'h04
`define PSQ_OFF_STAT    8'h08
`define PSQ_OFF_ICUT    8'h0c
`define PSQ_OFF_ILIM    8'h10

`define PSQ_CTRL_MODE_LO 0
`define PSQ_CTRL_MODE_HI 1
`define PSQ_CTRL_DETEN   2
`define PSQ_CTRL_CLSEN   3
`define PSQ_CTRL_LEGACY  4
`define PSQ_CTRL_HIPWR   5
`define PSQ_CTRL_TWOEV   6

`define PSQ_CMD_DET      0
`define PSQ_CMD_CLS      1
`define PSQ_CMD_PWRON    2
`define PSQ_CMD_PWROFF   3

`define PSQ_STAT_DET_LO  0
`define PSQ_STAT_DET_HI  2
`define PSQ_STAT_CLS_LO  4
`define PSQ_STAT_CLS_HI  6
`define PSQ_STAT_ON      8
`define PSQ_STAT_SECEV   9
`define PSQ_STAT_INRUSH  10
`define PSQ_STAT_STRAPA  12
`define PSQ_STAT_STRAPM  13

`define PSQ_THR_W        10
`define PSQ_ICUT_RST     10'h177
`define PSQ_ILIM_RST     10'h1a9
`define PSQ_ICUT_C1      10'h070
`define PSQ_ICUT_C2      10'h0ce
`define PSQ_ICUT_C3      10'h177
`define PSQ_ICUT_C4      10'h27e
`define PSQ_ILIM_T1      10'h1a9
`define PSQ_ILIM_T2      10'h352

`define PSQ_CLK_KHZ      200000
`define PSQ_BACKOFF_MS   100
`define PSQ_MIDSPAN_MS   2000
`define PSQ_CLASS_MS     12
`define PSQ_MARK_MS      2
`define PSQ_STRAP_WAIT   2'h2

`endif

// File: verilog/psq_pkg.sv
// Purpose: types shared by the sequencer and its surroundings
// Assumes: analog front end answers in the system clock domain
// Notes:   detection codes double as the front end's resistance bins
package psq_pkg;

  typedef enum logic [1:0] {
    MODE_SHUT   = 2'b00,
    MODE_MANUAL = 2'b01,
    MODE_SEMI   = 2'b10,
    MODE_AUTO   = 2'b11
  } psq_mode_t;

  typedef enum logic [2:0] {
    DET_UNKNOWN = 3'b000,
    DET_SHORT   = 3'b001,
    DET_CAPHIGH = 3'b010,
    DET_RLOW    = 3'b011,
    DET_GOOD    = 3'b100,
    DET_RHIGH   = 3'b101,
    DET_OPEN    = 3'b110,
    DET_RANGE   = 3'b111
  } psq_det_t;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_FI1   = 3'b001,
    OP_FI2   = 3'b010,
    OP_FV    = 3'b011,
    OP_CLASS = 3'b100,
    OP_MARK  = 3'b101
  } psq_op_t;

  typedef struct packed {
    psq_op_t op;
    logic    start;
  } psq_afe_cmd_t;

  typedef struct packed {
    logic       done;
    logic       vLow1V;
    logic       vOver10V;
    logic       capHigh;
    logic       legacyCap;
    psq_det_t   rBin;
    logic [2:0] cls;
  } psq_afe_res_t;

  typedef struct packed {
    logic [9:0] icut;
    logic [9:0] ilim;
  } psq_thr_t;

endpackage : psq_pkg

// File: verilog/psq_port_seq.sv
// Purpose: one port's detection, classification and power-on sequencer
// Assumes: front-end results arrive on clk_sys; straps are raw pins
// Notes:   the analog steps themselves live in the front end
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/10ps
`include "psq_regs.svh"

module psq_port_seq #(
  parameter int BACKOFF_CYC = `PSQ_BACKOFF_MS * `PSQ_CLK_KHZ,
  parameter int MIDSPAN_CYC = `PSQ_MIDSPAN_MS * `PSQ_CLK_KHZ,
  parameter int CLASS_CYC   = `PSQ_CLASS_MS * `PSQ_CLK_KHZ,
  parameter int MARK_CYC    = `PSQ_MARK_MS * `PSQ_CLK_KHZ
) (
  input  logic                 clk_sys,
  input  logic                 nrst,
  input  logic [7:0]           addr,
  input  logic [31:0]          wrData,
  input  logic                 wrEn,
  input  logic                 rdEn,
  output logic [31:0]          rdData_r,
  input  logic                 autoStrap,
  input  logic                 midStrap,
  input  psq_pkg::psq_afe_res_t afeRes,
  output psq_pkg::psq_afe_cmd_t afeCmd_r,
  output logic                 portOn_r,
  output psq_pkg::psq_thr_t    thr_r
);
  import psq_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_I1   = 4'b0001,
    ST_I2   = 4'b0010,
    ST_DV   = 4'b0011,
    ST_CLS1 = 4'b0100,
    ST_MARK = 4'b0101,
    ST_CLS2 = 4'b0110,
    ST_EVAL = 4'b0111,
    ST_BACK = 4'b1000,
    ST_ON   = 4'b1001
  } psq_state_t;

  function automatic psq_op_t opOf(input psq_state_t s);
    case (s)
      ST_I1:   opOf = OP_FI1;
      ST_I2:   opOf = OP_FI2;
      ST_DV:   opOf = OP_FV;
      ST_CLS1: opOf = OP_CLASS;
      ST_CLS2: opOf = OP_CLASS;
      ST_MARK: opOf = OP_MARK;
      default: opOf = OP_NONE;
    endcase
  endfunction : opOf

  function automatic psq_thr_t thrOf(input logic [2:0] c);
    case (c)
      3'h1:    thrOf = '{`PSQ_ICUT_C1, `PSQ_ILIM_T1};
      3'h2:    thrOf = '{`PSQ_ICUT_C2, `PSQ_ILIM_T1};
      3'h4:    thrOf = '{`PSQ_ICUT_C4, `PSQ_ILIM_T2};
      default: thrOf = '{`PSQ_ICUT_C3, `PSQ_ILIM_T1};
    endcase
  endfunction : thrOf

  psq_state_t state_r, state_nxt;
  psq_mode_t  mode_r, modeEff;
  psq_det_t   det_r, detVal;
  logic [2:0] cls_r, clsVal;
  logic       detEn_r, clsEn_r, legacyEn_r, hiPwr_r, twoEv_r;
  logic       secEv_r, inv_r, inrush_r;
  logic       autoS1_r, autoS2_r, midS1_r, midS2_r;
  logic       strapAuto_r, strapMid_r, captured_r;
  logic [1:0] capCnt_r;
  logic [31:0] cnt_r, cntVal;
  logic       detWr, clsWr, cntLoad, secSet, invSet, clsStart;
  logic       faultSet, autoThr, issue;
  logic       cmdWr, cmdDet, cmdCls, cmdOn, cmdOff;
  logic       detOk, clsOk, timeUp, hostOnOk;

  //////////////////////////////////////////////////////////////////////////
  // strap pins: two flops, then caught once after reset release

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      autoS1_r <= 1'b0;
      autoS2_r <= 1'b0;
      midS1_r  <= 1'b0;
      midS2_r  <= 1'b0;
    end else begin
      autoS1_r <= autoStrap;
      autoS2_r <= autoS1_r;
      midS1_r  <= midStrap;
      midS2_r  <= midS1_r;
    end
  end

  // the strap is only honoured as sampled here; later edges are ignored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      capCnt_r    <= 2'h0;
      captured_r  <= 1'b0;
      strapAuto_r <= 1'b0;
      strapMid_r  <= 1'b0;
    end else if (!captured_r) begin
      capCnt_r <= capCnt_r + 2'h1;
      if (capCnt_r == `PSQ_STRAP_WAIT) begin
        captured_r  <= 1'b1;
        strapAuto_r <= autoS2_r;
        strapMid_r  <= midS2_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register bus

  assign cmdWr  = wrEn && (addr == `PSQ_OFF_CMD);
  assign cmdDet = cmdWr && wrData[`PSQ_CMD_DET];
  assign cmdCls = cmdWr && wrData[`PSQ_CMD_CLS];
  assign cmdOn  = cmdWr && wrData[`PSQ_CMD_PWRON];
  assign cmdOff = cmdWr && wrData[`PSQ_CMD_PWROFF];

  // enables default to the strap: a part strapped low starts inhibited
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_r     <= MODE_SHUT;
      detEn_r    <= 1'b0;
      clsEn_r    <= 1'b0;
      legacyEn_r <= 1'b0;
      hiPwr_r    <= 1'b0;
      twoEv_r    <= 1'b0;
    end else if (!captured_r && capCnt_r == `PSQ_STRAP_WAIT) begin
      mode_r  <= autoS2_r ? MODE_AUTO : MODE_SHUT;
      detEn_r <= autoS2_r;
      clsEn_r <= autoS2_r;
    end else if (wrEn && addr == `PSQ_OFF_CTRL) begin
      mode_r     <= psq_mode_t'(
                    wrData[`PSQ_CTRL_MODE_HI:`PSQ_CTRL_MODE_LO]);
      detEn_r    <= wrData[`PSQ_CTRL_DETEN];
      clsEn_r    <= wrData[`PSQ_CTRL_CLSEN];
      legacyEn_r <= wrData[`PSQ_CTRL_LEGACY];
      hiPwr_r    <= wrData[`PSQ_CTRL_HIPWR];
      twoEv_r    <= wrData[`PSQ_CTRL_TWOEV];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdData_r <= 32'h0;
    end else if (!rdEn) begin
      rdData_r <= 32'h0;
    end else begin
      case (addr)
        `PSQ_OFF_CTRL: rdData_r <= {25'h0, twoEv_r, hiPwr_r, legacyEn_r,
                                    clsEn_r, detEn_r, mode_r};
        `PSQ_OFF_STAT: rdData_r <= {18'h0, strapMid_r, strapAuto_r, 1'b0,
                                    inrush_r, secEv_r, portOn_r, 1'b0,
                                    cls_r, 1'b0, det_r};
        `PSQ_OFF_ICUT: rdData_r <= {22'h0, thr_r.icut};
        `PSQ_OFF_ILIM: rdData_r <= {22'h0, thr_r.ilim};
        default:       rdData_r <= 32'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer

  // automatic mode without the strap is a reserved setting: treat as off
  assign modeEff  = (mode_r == MODE_AUTO && !strapAuto_r) ? MODE_SHUT
                                                          : mode_r;
  assign detOk    = detEn_r && modeEff != MODE_SHUT;
  assign clsOk    = clsEn_r && modeEff != MODE_SHUT;
  assign timeUp   = (cnt_r == 32'h0);
  assign hostOnOk = (modeEff == MODE_MANUAL) || (modeEff == MODE_SEMI);

  always_comb begin
    state_nxt = state_r;
    detWr     = 1'b0;
    detVal    = det_r;
    clsWr     = 1'b0;
    clsVal    = cls_r;
    cntLoad   = 1'b0;
    cntVal    = 32'h0;
    secSet    = 1'b0;
    invSet    = 1'b0;
    clsStart  = 1'b0;
    faultSet  = 1'b0;
    autoThr   = 1'b0;
    case (state_r)
      ST_IDLE, ST_BACK: begin
        if (cmdOn && hostOnOk) begin
          // manual forces power; semi-auto with high power checks result
          if (modeEff == MODE_MANUAL || !hiPwr_r || det_r == DET_GOOD)
            state_nxt = ST_ON;
          else
            faultSet = 1'b1;
        end else if (state_r == ST_BACK) begin
          if (timeUp)
            state_nxt = ST_IDLE;
        end else if (modeEff == MODE_MANUAL) begin
          if (cmdDet && detOk)
            state_nxt = ST_I1;
          else if (cmdCls && clsOk)
            state_nxt = ST_CLS1;
        end else if (detOk) begin
          state_nxt = ST_I1;
        end
      end
      ST_I1: begin
        if (afeRes.done) begin
          if (afeRes.vLow1V) begin
            detWr     = 1'b1;
            detVal    = DET_SHORT;
            state_nxt = ST_EVAL;
          end else if (afeRes.vOver10V) begin
            detWr     = 1'b1;
            detVal    = DET_RANGE;
            state_nxt = ST_EVAL;
          end else begin
            state_nxt = ST_I2;
          end
        end
      end
      ST_I2: begin
        if (afeRes.done) begin
          if (legacyEn_r && afeRes.legacyCap) begin
            detWr     = 1'b1;
            detVal    = DET_GOOD;
            state_nxt = (clsOk && modeEff != MODE_MANUAL) ? ST_CLS1
                                                          : ST_EVAL;
          end else if (afeRes.capHigh) begin
            detWr     = 1'b1;
            detVal    = DET_CAPHIGH;
            state_nxt = ST_EVAL;
          end else if (afeRes.rBin == DET_GOOD) begin
            state_nxt = ST_DV;
          end else begin
            detWr     = 1'b1;
            detVal    = afeRes.rBin;
            state_nxt = ST_EVAL;
          end
        end
      end
      ST_DV: begin
        if (afeRes.done) begin
          detWr  = 1'b1;
          detVal = afeRes.rBin;
          if (afeRes.rBin == DET_GOOD && clsOk && modeEff != MODE_MANUAL)
            state_nxt = ST_CLS1;
          else
            state_nxt = ST_EVAL;
        end
      end
      ST_CLS1: begin
        if (timeUp) begin
          clsWr  = 1'b1;
          clsVal = afeRes.cls;
          if (afeRes.cls == 3'h4 && twoEv_r)
            state_nxt = ST_MARK;
          else
            state_nxt = ST_EVAL;
        end
      end
      ST_MARK: begin
        if (timeUp) begin
          state_nxt = ST_CLS2;
          secSet    = 1'b1;
        end
      end
      ST_CLS2: begin
        if (timeUp) begin
          clsWr     = 1'b1;
          clsVal    = afeRes.cls;
          invSet    = (afeRes.cls != 3'h4);
          state_nxt = ST_EVAL;
        end
      end
      ST_EVAL: begin
        if (modeEff == MODE_AUTO && det_r == DET_GOOD && !inv_r) begin
          state_nxt = ST_ON;
          autoThr   = 1'b1;
        end else if (modeEff != MODE_MANUAL && det_r == DET_GOOD) begin
          state_nxt = ST_BACK;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ON: begin
        if (cmdOff)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (modeEff == MODE_SHUT)
      state_nxt = ST_IDLE;
    // a cleared enable aborts a detection under way, result unchanged
    if (!detOk && (state_r == ST_I1 || state_r == ST_I2 ||
                   state_r == ST_DV)) begin
      state_nxt = ST_IDLE;
      detWr     = 1'b0;
    end
    if (state_nxt != state_r) begin
      case (state_nxt)
        ST_CLS1: begin
          cntLoad  = 1'b1;
          cntVal   = 32'(CLASS_CYC - 1);
          clsStart = 1'b1;
        end
        ST_CLS2: begin
          cntLoad = 1'b1;
          cntVal  = 32'(CLASS_CYC - 1);
        end
        ST_MARK: begin
          cntLoad = 1'b1;
          cntVal  = 32'(MARK_CYC - 1);
        end
        ST_BACK: begin
          cntLoad = 1'b1;
          cntVal  = strapMid_r ? 32'(MIDSPAN_CYC - 1)
                               : 32'(BACKOFF_CYC - 1);
        end
        default: cntLoad = 1'b0;
      endcase
    end
  end

  assign issue = (state_nxt != state_r) &&
                 (state_nxt == ST_I1 || state_nxt == ST_I2 ||
                  state_nxt == ST_DV);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 32'h0;
    end else if (cntLoad) begin
      cnt_r <= cntVal;
    end else if (!timeUp) begin
      cnt_r <= cnt_r - 32'h1;
    end
  end

  // results stand until the next completed step rewrites them
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      det_r <= DET_UNKNOWN;
      cls_r <= 3'h0;
    end else begin
      if (detWr)
        det_r <= detVal;
      if (clsWr)
        cls_r <= clsVal;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      secEv_r <= 1'b0;
      inv_r   <= 1'b0;
    end else if (clsStart) begin
      secEv_r <= 1'b0;
      inv_r   <= 1'b0;
    end else begin
      secEv_r <= secEv_r | secSet;
      inv_r   <= inv_r | invSet;
    end
  end

  // a new fault in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      inrush_r <= 1'b0;
    end else begin
      inrush_r <= faultSet | (inrush_r &
                  ~(wrEn && addr == `PSQ_OFF_STAT &&
                    wrData[`PSQ_STAT_INRUSH]));
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      thr_r <= '{`PSQ_ICUT_RST, `PSQ_ILIM_RST};
    end else if (autoThr) begin
      thr_r <= thrOf(cls_r);
    end else begin
      // host writes land powered or not, except in the cycle the class limits load
      if (wrEn && addr == `PSQ_OFF_ICUT)
        thr_r.icut <= wrData[`PSQ_THR_W-1:0];
      if (wrEn && addr == `PSQ_OFF_ILIM)
        thr_r.ilim <= wrData[`PSQ_THR_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      afeCmd_r <= '{OP_NONE, 1'b0};
      portOn_r <= 1'b0;
    end else begin
      afeCmd_r <= '{opOf(state_nxt), issue};
      portOn_r <= (state_nxt == ST_ON);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  property p_short;
    state_r == ST_I1 && afeRes.done && afeRes.vLow1V && detOk
      |=> det_r == DET_SHORT && state_r == ST_EVAL;
  endproperty
  a_short: assert property (p_short)
    else $error("low first step did not report short");

  property p_range;
    state_r == ST_I1 && afeRes.done && !afeRes.vLow1V && afeRes.vOver10V &&
      detOk |=> det_r == DET_RANGE;
  endproperty
  a_range: assert property (p_range)
    else $error("high port voltage not reported");

  property p_vphase;
    afeCmd_r.start && afeCmd_r.op == OP_FV
      |-> $past(state_r) == ST_I2 && $past(afeRes.rBin) == DET_GOOD;
  endproperty
  a_vphase: assert property (p_vphase)
    else $error("voltage phase without good current phase");

  property p_manual;
    state_r == ST_IDLE && modeEff == MODE_MANUAL && !cmdWr ##1 !cmdWr
      |-> state_r == ST_IDLE;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual port left idle without command");

  property p_semi;
    $rose(portOn_r) && $past(modeEff) == MODE_SEMI |-> $past(cmdOn);
  endproperty
  a_semi: assert property (p_semi)
    else $error("semi-auto port powered without command");

  property p_fault;
    cmdOn && state_r == ST_IDLE && modeEff == MODE_SEMI && hiPwr_r &&
      det_r != DET_GOOD |=> inrush_r ##1 !portOn_r;
  endproperty
  a_fault: assert property (p_fault)
    else $error("bad detect power-on did not fault");

  property p_auto;
    state_r == ST_EVAL && modeEff == MODE_AUTO && det_r == DET_GOOD &&
      !inv_r |=> ##1 portOn_r && thr_r == thrOf(cls_r);
  endproperty
  a_auto: assert property (p_auto)
    else $error("automatic port not powered with limits");

  property p_inhibit;
    afeCmd_r.start |-> $past(detEn_r) && $past(modeEff) != MODE_SHUT;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("detection ran while inhibited");

  property p_cls;
    $rose(state_r == ST_CLS1) |-> (afeCmd_r.op == OP_CLASS)[*3];
  endproperty
  a_cls: assert property (p_cls)
    else $error("class voltage not held");

  property p_second;
    state_r == ST_MARK ##1 state_r == ST_CLS2 |-> secEv_r;
  endproperty
  a_second: assert property (p_second)
    else $error("second event flag missing");

  property p_back;
    $rose(state_r == ST_BACK) |-> (state_r == ST_BACK)[*2];
  endproperty
  a_back: assert property (p_back)
    else $error("back-off ended at once");

  c_good:  cover property (detWr && detVal == DET_GOOD);
  c_short: cover property (detWr && detVal == DET_SHORT);
  c_two:   cover property (secSet);
  c_auto:  cover property (autoThr);

endmodule : psq_port_seq

// File: testbench/psq_afe_model.sv
// Purpose: front-end stand-in that answers detect and class steps
// Assumes: one step in flight at a time; dly sets the answer delay
// Notes:   outside an answer done is low and the other fields carry inverted junk, except cls during a class step
`timescale 1ns/10ps
module psq_afe_model (
  input  logic                        clk_sys,
  input  psq_pkg::psq_afe_cmd_t       cmd,
  input  logic [3:0]                  dly,
  input  psq_pkg::psq_afe_res_t [2:0] plan,
  input  logic [1:0][2:0]             clsPlan,
  output psq_pkg::psq_afe_res_t       res
);
  import psq_pkg::*;
  psq_op_t      op_r   = OP_NONE;
  logic [3:0]   cnt_r  = 4'h0;
  logic         pend_r = 1'b0;
  logic         mark_r = 1'b0;
  psq_afe_res_t pick;

  always @(posedge clk_sys) begin
    if (cmd.start) begin
      pend_r <= 1'b1;
      cnt_r  <= dly;
      op_r   <= cmd.op;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      pend_r <= 1'b0;
    end
    // second class pulse follows a mark step
    mark_r <= (cmd.op == OP_MARK) | (mark_r & (cmd.op != OP_NONE));
  end

  always_comb begin
    pick = (op_r == OP_FI1) ? plan[0] :
           (op_r == OP_FI2) ? plan[1] : plan[2];
    res = (pend_r && cnt_r == 4'h0) ? pick : ~pick;
    res.done = pend_r && cnt_r == 4'h0;
    res.cls = (cmd.op == OP_CLASS) ? clsPlan[mark_r] : ~clsPlan[mark_r];
  end
endmodule : psq_afe_model

// File: testbench/psq_port_seq_bench.sv
// Purpose: self-checking bench for the port sequencer
// Assumes: shortened back-off and class timing parameters
// Notes:   detect outcomes come from a table run in manual mode
`timescale 1ns/10ps
module psq_port_seq_bench;
  import psq_pkg::*;
  localparam int BO = 20;
  localparam int CC = 10;
  logic clk_sys = 0, nrst = 0, wrEn = 0, rdEn = 0;
  logic autoStrap = 0, midStrap = 0, portOn_r;
  logic [7:0] addr = 0;
  logic [31:0] wrData = 0, rdData_r, rv;
  logic [3:0] dly = 0;
  logic [9:0] v;
  psq_afe_res_t afeRes;
  psq_afe_res_t [2:0] plan = '0, p;
  logic [1:0][2:0] clsPlan = '0;
  psq_afe_cmd_t afeCmd_r;
  psq_thr_t thr_r;
  int fails = 0, checks = 0, seed = 71594;
  int starts = 0, clsCyc = 0, idle = 0, lastGap = 0, n, n0, c0;
  int tw[6] = '{0, 1, 1, 1, 0, 1}, ca[6] = '{3, 3, 4, 4, 4, 0};
  int cb[6] = '{5, 5, 4, 2, 5, 5}, ac[4] = '{1, 2, 0, 4};
  int ic[4] = '{112, 206, 375, 638}, il[4] = '{425, 425, 425, 850};
  logic ev2;

  psq_port_seq #(.BACKOFF_CYC(BO), .MIDSPAN_CYC(40), .CLASS_CYC(CC),
    .MARK_CYC(5)) psq_port_seq_i (.clk_sys(clk_sys), .nrst(nrst),
    .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData_r(rdData_r), .autoStrap(autoStrap), .midStrap(midStrap),
    .afeRes(afeRes), .afeCmd_r(afeCmd_r), .portOn_r(portOn_r),
    .thr_r(thr_r));
  psq_afe_model psq_afe_model_i (.clk_sys(clk_sys), .cmd(afeCmd_r),
    .dly(dly), .plan(plan), .clsPlan(clsPlan), .res(afeRes));

  initial forever #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (afeCmd_r.start) starts <= starts + 1;
    if (afeCmd_r.op == OP_CLASS) clsCyc <= clsCyc + 1;
    idle <= afeRes.done ? 0 : idle + 1;
    if (afeCmd_r.start && afeCmd_r.op == OP_FI1) lastGap <= idle;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wrData <= d;
    wrEn <= 1;
    @(posedge clk_sys);
    wrEn <= 0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    addr <= a;
    rdEn <= 1;
    @(posedge clk_sys);
    rdEn <= 0;
    #1 rv = rdData_r;
    @(posedge clk_sys);
  endtask : rd

  // issue a command and wait until the front-end steps are over
  task automatic run(input logic [31:0] c);
    int seen = 0;
    wr(8'h04, c);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      if (afeCmd_r.op != OP_NONE) seen = 1;
      else if (seen) break;
    end
  endtask : run

  function automatic logic [2:0] expDet(input logic leg, output int k);
    k = 1;
    if (p[0].vLow1V) return DET_SHORT;
    if (p[0].vOver10V) return DET_RANGE;
    k = 2;
    if (p[1].legacyCap && leg) return DET_GOOD;
    if (p[1].capHigh) return DET_CAPHIGH;
    if (p[1].rBin != DET_GOOD) return p[1].rBin;
    k = 3;
    return p[2].rBin;
  endfunction : expDet

  task automatic final_report;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1;
    repeat (6) @(posedge clk_sys);
    rd(8'h0c);
    chk(rv, 32'h177);
    rd(8'h14);
    chk(rv, 32'h0);
    wr(8'h00, 32'h01);
    run(1);
    chk(starts, 0);
    for (int k = 0; k < 10; k++) begin
      p = '0;
      p[1].rBin = DET_GOOD;
      p[2].rBin = DET_GOOD;
      case (k)
        0: p[0].vLow1V = 1;
        1: p[0].vOver10V = 1;
        2: p[1].capHigh = 1;
        3: p[1].rBin = DET_RLOW;
        4: p[1].rBin = DET_RHIGH;
        5: p[1].rBin = DET_OPEN;
        6: p[2].rBin = DET_RHIGH;
        7, 8: begin
          p[1].legacyCap = 1;
          p[1].rBin = DET_OPEN;
        end
        default: ;
      endcase
      plan <= p;
      dly <= 4'($random(seed));
      wr(8'h00, 32'h0d | (32'(k == 7) << 4));
      n0 = starts;
      c0 = clsCyc;
      run(1);
      repeat (30) @(posedge clk_sys);
      rd(8'h08);
      chk(rv[2:0], expDet(k == 7, n));
      chk(starts - n0, n);
      chk(clsCyc - c0, 0);
    end
    for (int k = 0; k < 6; k++) begin
      ev2 = tw[k] == 1 && ca[k] == 4;
      clsPlan <= {3'(cb[k]), 3'(ca[k])};
      wr(8'h00, 32'h09 | (32'(tw[k]) << 6));
      n0 = clsCyc;
      run(2);
      repeat (5) @(posedge clk_sys);
      rd(8'h08);
      chk(rv[6:4], ev2 ? cb[k] : ca[k]);
      chk(rv[9], ev2);
      chk(clsCyc - n0, ev2 ? 2 * CC : CC);
    end
    p = '0;
    p[1].rBin = DET_GOOD;
    p[2].rBin = DET_RHIGH;
    plan <= p;
    wr(8'h00, 32'h05);
    run(1);
    wr(8'h00, 32'h22);
    repeat (5) @(posedge clk_sys);
    rd(8'h08);
    chk(rv[2:0], DET_RHIGH);
    wr(8'h04, 32'h04);
    rd(8'h08);
    chk(rv[10], 1);
    chk(portOn_r, 0);
    wr(8'h00, 32'h21);
    wr(8'h04, 32'h04);
    chk(portOn_r, 1);
    wr(8'h04, 32'h08);
    wr(8'h00, 32'h26);
    repeat (100) @(posedge clk_sys);
    chk(lastGap < BO, 1);
    p[2].rBin = DET_GOOD;
    plan <= p;
    repeat (150) @(posedge clk_sys);
    chk(lastGap >= BO, 1);
    chk(portOn_r, 0);
    rd(8'h08);
    chk(rv[2:0], DET_GOOD);
    wr(8'h00, 32'h22);
    repeat (60) @(posedge clk_sys);
    wr(8'h04, 32'h04);
    repeat (3) @(posedge clk_sys);
    chk(portOn_r, 1);
    v = 10'($random(seed));
    wr(8'h0c, {22'h0, v});
    rd(8'h0c);
    chk(rv, {22'h0, v});
    chk(thr_r.icut, v);
    wr(8'h04, 32'h08);
    repeat (3) @(posedge clk_sys);
    chk(portOn_r, 0);
    plan <= p;
    autoStrap <= 1;
    midStrap <= 1;
    for (int k = 0; k < 4; k++) begin
      clsPlan <= {3'(ac[k]), 3'(ac[k])};
      nrst <= 0;
      repeat (4) @(posedge clk_sys);
      nrst <= 1;
      for (int i = 0; i < 500 && portOn_r !== 1; i++) @(posedge clk_sys);
      chk(portOn_r, 1);
      chk(thr_r, {10'(ic[k]), 10'(il[k])});
      rd(8'h08);
      chk(rv[13:12], 2'b11);
      chk(rv[6:4], ac[k]);
    end
    final_report();
  end
endmodule : psq_port_seq_bench
